// ### sau_pkg.sv
package sau_pkg;

   localparam int unsigned DATA_W = 32;
   localparam int unsigned HALF_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned WIDE_W = 34;
   localparam int unsigned LANE_W = 18;
   localparam int unsigned POS_W = 6;
   localparam int unsigned SHAMT_W = 5;
   localparam int unsigned DEST_W = 4;
   localparam int unsigned FLAGS_W = 4;

   localparam logic [5:0] SCLAMP_N_MIN = 6'h01;
   localparam logic [5:0] SCLAMP_N_MAX = 6'h20;
   localparam logic [5:0] UCLAMP_N_MAX = 6'h1f;
   localparam logic [5:0] DUAL_S_N_MIN = 6'h01;
   localparam logic [5:0] DUAL_S_N_MAX = 6'h10;
   localparam logic [5:0] DUAL_U_N_MAX = 6'h0f;
   localparam logic [4:0] ASR_AMT_MIN = 5'h01;
   localparam logic [5:0] WORD_N = 6'h20;
   localparam logic [4:0] BYTE_N = 5'h08;
   localparam logic [4:0] HALF_N = 5'h10;

   localparam logic SAT_FLAG_RESET = 1'b0;
   localparam int unsigned SAT_FLAG_POS = 4;
   localparam int unsigned STATUS_PAD_W = 27;

   typedef enum logic [11:0] {
      OP_SIGNED_CLAMP = 12'h001,
      OP_UNSIGNED_CLAMP = 12'h002,
      OP_DUAL_HALF_SIGNED_CLAMP = 12'h004,
      OP_DUAL_HALF_UNSIGNED_CLAMP = 12'h008,
      OP_SAT_WORD_ADD = 12'h010,
      OP_SAT_WORD_SUB = 12'h020,
      OP_SAT_HALF_LANE_ADD = 12'h040,
      OP_SAT_HALF_LANE_SUB = 12'h080,
      OP_SAT_BYTE_LANE_ADD = 12'h100,
      OP_SAT_BYTE_LANE_SUB = 12'h200,
      OP_SAT_ADD_SUB_EXCHANGE = 12'h400,
      OP_SAT_SUB_ADD_EXCHANGE = 12'h800
   } sau_op_t;

endpackage

// ### sau_clamp_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sau_clamp_if;
   logic signed [33:0] value;
   logic [5:0] width;
   logic is_unsigned;
   logic [31:0] result;
   logic saturated;

   modport user (
      output value,
      output width,
      output is_unsigned,
      input result,
      input saturated
   );

   modport clamp (
      input value,
      input width,
      input is_unsigned,
      output result,
      output saturated
   );
endinterface

`default_nettype wire

// ### sau_word_clamp.sv
`timescale 1ns/1ps
`default_nettype none

module sau_word_clamp
   import sau_pkg::*;
(
   sau_clamp_if.clamp port
);

   logic signed [33:0] lim_hi;
   logic signed [33:0] lim_lo;
   logic signed [33:0] clamped;

   // Limits of the n-bit signed or unsigned range around the wide value.
   always_comb begin
      if (port.is_unsigned) begin
         lim_lo = '0;
         lim_hi = (34'sd1 <<< port.width) - 34'sd1;
      end else begin
         lim_hi = (34'sd1 <<< (port.width - 6'h01)) - 34'sd1;
         lim_lo = -(34'sd1 <<< (port.width - 6'h01));
      end
   end

   always_comb begin
      if (port.value > lim_hi) begin
         clamped = lim_hi;
         port.saturated = 1'b1;
      end else if (port.value < lim_lo) begin
         clamped = lim_lo;
         port.saturated = 1'b1;
      end else begin
         clamped = port.value;
         port.saturated = 1'b0;
      end
      port.result = clamped[31:0];
   end

endmodule

`default_nettype wire

// ### sau_top.sv
// Operation
// - Signed single clamp accepts saturation widths 1 through 32.
// - Unsigned single clamp accepts saturation widths 0 through 31.
// - Signed clamp shifts first, then limits to the signed n-bit range.
// - Unsigned clamp shifts first, negatives become zero, top is 2^n-1.
// - A clamp that changes the value sets the sticky flag.
// - Only a status write or reset clears the sticky flag; status read shows it.
// - Optional pre-shift: arithmetic right 1-31 or logical left 0-31.
// - Condition flags are never altered; only the sticky flag may be.
// - Dual-half signed clamp accepts widths 1 to 16 for both lanes.
// - Dual-half unsigned clamp accepts widths 0 to 15 for both lanes.
// - Dual-half clamps treat each signed half independently.
// - Saturating add and subtract work on word, half or byte lanes.
// - Only word add and subtract set the sticky flag on clamping.
// - Add-sub exchange: high = a.hi + b.lo, low = a.lo - b.hi.
// - Sub-add exchange: high = a.hi - b.lo, low = a.lo + b.hi.
// - A failed condition code suppresses the register writeback.
`timescale 1ns/1ps
`default_nettype none

module sau_top
   import sau_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic issue_valid_i,
   input wire sau_op_t op_i,
   input wire logic cond_pass_i,
   input wire logic [5:0] sat_pos_i,
   input wire logic shift_asr_i,
   input wire logic [4:0] shift_amt_i,
   input wire logic [31:0] opa_i,
   input wire logic [31:0] opb_i,
   input wire logic [3:0] dest_idx_i,
   input wire logic status_wr_i,
   input wire logic status_wr_sat_i,
   input wire logic status_rd_i,
   input wire logic [3:0] nzcv_i,
   output logic wb_valid_o,
   output logic [3:0] wb_dest_o,
   output logic [31:0] wb_data_o,
   output logic op_err_o,
   output logic sat_flag_o,
   output logic status_rd_valid_o,
   output logic [31:0] status_rd_data_o
);

   // Clamps an 18-bit signed lane value to an n-bit range of a lane.
   // The top bit of the answer marks that the value was changed.
   function automatic logic [16:0] lane_clamp(
      input logic signed [17:0] v,
      input logic [4:0] n,
      input logic uns
   );
      logic signed [17:0] hi;
      logic signed [17:0] lo;
      logic [16:0] r;
      if (uns) begin
         lo = '0;
         hi = (18'sd1 <<< n) - 18'sd1;
      end else begin
         hi = (18'sd1 <<< (n - 5'h01)) - 18'sd1;
         lo = -(18'sd1 <<< (n - 5'h01));
      end
      if (v > hi) begin
         r = {1'b1, hi[15:0]};
      end else if (v < lo) begin
         r = {1'b1, lo[15:0]};
      end else begin
         r = {1'b0, v[15:0]};
      end
      return r;
   endfunction

   sau_clamp_if word_if ();

   sau_word_clamp u_word_clamp (
      .port (word_if.clamp)
   );

   logic wb_valid_reg;
   logic [3:0] wb_dest_reg;
   logic [31:0] wb_data_reg;
   logic op_err_reg;
   logic sat_flag_reg;
   logic sat_flag_next;
   logic status_rd_valid_reg;
   logic [31:0] status_rd_data_reg;

   logic [31:0] shifted;
   logic shift_ok;
   logic is_clamp_op;
   logic legal;
   logic sets_flag;
   logic [31:0] result;
   logic accept;
   logic [4:0] dual_n;
   logic dual_uns;
   logic [15:0] half_res [2];
   logic [1:0] half_sat;
   logic [7:0] byte_res [4];

   // Arithmetic right shift must move at least one bit.
   always_comb begin
      if (shift_asr_i) begin
         shifted = 32'($signed(opa_i) >>> shift_amt_i);
         shift_ok = (shift_amt_i >= ASR_AMT_MIN);
      end else begin
         shifted = opa_i << shift_amt_i;
         shift_ok = 1'b1;
      end
   end

   assign is_clamp_op = (op_i == OP_SIGNED_CLAMP) ||
                        (op_i == OP_UNSIGNED_CLAMP);

   // The shared word path clamps single values and word add or subtract.
   always_comb begin
      word_if.is_unsigned = (op_i == OP_UNSIGNED_CLAMP);
      if (is_clamp_op) begin
         word_if.value = 34'($signed(shifted));
         word_if.width = sat_pos_i;
      end else if (op_i == OP_SAT_WORD_SUB) begin
         word_if.value = 34'($signed(opa_i)) - 34'($signed(opb_i));
         word_if.width = WORD_N;
      end else begin
         word_if.value = 34'($signed(opa_i)) + 34'($signed(opb_i));
         word_if.width = WORD_N;
      end
   end

   assign dual_n = sat_pos_i[4:0];
   assign dual_uns = (op_i == OP_DUAL_HALF_UNSIGNED_CLAMP);

   // Each half lane is computed on its own; the exchange forms pair a
   // lane of the first operand with the opposite lane of the second.
   for (genvar h = 0; h < 2; h++) begin : g_half
      logic signed [17:0] a_ext;
      logic signed [17:0] b_ext;
      logic signed [17:0] bx_ext;
      logic signed [17:0] lane_val;
      logic [4:0] lane_n;
      logic lane_uns;
      logic [16:0] lane_out;

      assign a_ext = 18'($signed(opa_i[16*h +: 16]));
      assign b_ext = 18'($signed(opb_i[16*h +: 16]));
      assign bx_ext = 18'($signed(opb_i[16*(1-h) +: 16]));

      always_comb begin
         lane_n = HALF_N;
         lane_uns = 1'b0;
         unique case (op_i)
            OP_DUAL_HALF_SIGNED_CLAMP,
            OP_DUAL_HALF_UNSIGNED_CLAMP: begin
               lane_val = a_ext;
               lane_n = dual_n;
               lane_uns = dual_uns;
            end
            OP_SAT_HALF_LANE_SUB: begin
               lane_val = a_ext - b_ext;
            end
            OP_SAT_ADD_SUB_EXCHANGE: begin
               if (h == 1) begin
                  lane_val = a_ext + bx_ext;
               end else begin
                  lane_val = a_ext - bx_ext;
               end
            end
            OP_SAT_SUB_ADD_EXCHANGE: begin
               if (h == 1) begin
                  lane_val = a_ext - bx_ext;
               end else begin
                  lane_val = a_ext + bx_ext;
               end
            end
            default: begin
               lane_val = a_ext + b_ext;
            end
         endcase
      end

      assign lane_out = lane_clamp(lane_val, lane_n, lane_uns);
      assign half_res[h] = lane_out[15:0];
      assign half_sat[h] = lane_out[16];
   end

   // Four independent byte lanes, each limited to the signed byte range.
   for (genvar b = 0; b < 4; b++) begin : g_byte
      logic signed [17:0] a_ext;
      logic signed [17:0] b_ext;
      logic signed [17:0] lane_val;
      logic [16:0] lane_out;

      assign a_ext = 18'($signed(opa_i[8*b +: 8]));
      assign b_ext = 18'($signed(opb_i[8*b +: 8]));

      always_comb begin
         if (op_i == OP_SAT_BYTE_LANE_SUB) begin
            lane_val = a_ext - b_ext;
         end else begin
            lane_val = a_ext + b_ext;
         end
      end

      assign lane_out = lane_clamp(lane_val, BYTE_N, 1'b0);
      assign byte_res[b] = lane_out[7:0];
   end

   // Operation decode: legality of the width, the result and the flag.
   always_comb begin
      legal = 1'b1;
      sets_flag = 1'b0;
      result = word_if.result;
      unique case (op_i)
         OP_SIGNED_CLAMP: begin
            legal = shift_ok && (sat_pos_i >= SCLAMP_N_MIN) &&
                    (sat_pos_i <= SCLAMP_N_MAX);
            sets_flag = word_if.saturated;
         end
         OP_UNSIGNED_CLAMP: begin
            legal = shift_ok && (sat_pos_i <= UCLAMP_N_MAX);
            sets_flag = word_if.saturated;
         end
         OP_DUAL_HALF_SIGNED_CLAMP: begin
            legal = (sat_pos_i >= DUAL_S_N_MIN) &&
                    (sat_pos_i <= DUAL_S_N_MAX);
            sets_flag = |half_sat;
            result = {half_res[1], half_res[0]};
         end
         OP_DUAL_HALF_UNSIGNED_CLAMP: begin
            legal = (sat_pos_i <= DUAL_U_N_MAX);
            sets_flag = |half_sat;
            result = {half_res[1], half_res[0]};
         end
         OP_SAT_WORD_ADD,
         OP_SAT_WORD_SUB: begin
            sets_flag = word_if.saturated;
         end
         OP_SAT_HALF_LANE_ADD,
         OP_SAT_HALF_LANE_SUB,
         OP_SAT_ADD_SUB_EXCHANGE,
         OP_SAT_SUB_ADD_EXCHANGE: begin
            result = {half_res[1], half_res[0]};
         end
         OP_SAT_BYTE_LANE_ADD,
         OP_SAT_BYTE_LANE_SUB: begin
            result = {byte_res[3], byte_res[2],
                      byte_res[1], byte_res[0]};
         end
         default: begin
            legal = 1'b0;
         end
      endcase
   end

   // Register numbers are taken as given; the issuer keeps the stack
   // pointer and program counter out of these operations.
   assign accept = issue_valid_i && cond_pass_i && legal;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_valid_reg <= 1'b0;
      end else begin
         wb_valid_reg <= accept;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dest_reg <= '0;
         wb_data_reg <= '0;
      end else if (accept) begin
         wb_dest_reg <= dest_idx_i;
         wb_data_reg <= result;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         op_err_reg <= 1'b0;
      end else begin
         op_err_reg <= issue_valid_i && cond_pass_i && !legal;
      end
   end

   // A saturation in the same cycle as a status write wins over it.
   always_comb begin
      sat_flag_next = sat_flag_reg;
      if (status_wr_i) begin
         sat_flag_next = status_wr_sat_i;
      end
      if (accept && sets_flag) begin
         sat_flag_next = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sat_flag_reg <= SAT_FLAG_RESET;
      end else begin
         sat_flag_reg <= sat_flag_next;
      end
   end

   // The condition flags are only reflected, never written.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_rd_valid_reg <= 1'b0;
         status_rd_data_reg <= '0;
      end else begin
         status_rd_valid_reg <= status_rd_i;
         if (status_rd_i) begin
            status_rd_data_reg <= {{STATUS_PAD_W{1'b0}}, sat_flag_reg,
                                   nzcv_i};
         end
      end
   end

   assign wb_valid_o = wb_valid_reg;
   assign wb_dest_o = wb_dest_reg;
   assign wb_data_o = wb_data_reg;
   assign op_err_o = op_err_reg;
   assign sat_flag_o = sat_flag_reg;
   assign status_rd_valid_o = status_rd_valid_reg;
   assign status_rd_data_o = status_rd_data_reg;

endmodule

`default_nettype wire

// ### sau_regfile_model.sv
`timescale 1ns/1ps
`default_nettype none

module sau_regfile_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_valid_i,
   input wire logic [3:0] wb_dest_i,
   input wire logic [31:0] wb_data_i,
   output logic [3:0] dest_o
);
   // Destinations rotate over the general registers and never reach 13-15.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dest_o <= 4'h0;
      end else if (wb_valid_i) begin
         dest_o <= (dest_o == 4'hc) ? 4'h0 : dest_o + 4'h1;
      end
   end
endmodule

`default_nettype wire

// ### sau_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module sau_top_asserts
   import sau_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic issue_valid_i,
   input wire sau_op_t op_i,
   input wire logic cond_pass_i,
   input wire logic [5:0] sat_pos_i,
   input wire logic shift_asr_i,
   input wire logic [4:0] shift_amt_i,
   input wire logic [31:0] opa_i,
   input wire logic [31:0] opb_i,
   input wire logic [3:0] dest_idx_i,
   input wire logic status_wr_i,
   input wire logic status_wr_sat_i,
   input wire logic status_rd_i,
   input wire logic [3:0] nzcv_i,
   input wire logic wb_valid_o,
   input wire logic [3:0] wb_dest_o,
   input wire logic [31:0] wb_data_o,
   input wire logic op_err_o,
   input wire logic sat_flag_o,
   input wire logic status_rd_valid_o,
   input wire logic [31:0] status_rd_data_o
);
   logic [31:0] ab_sum;
   assign ab_sum = opa_i + opb_i;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_take;
      issue_valid_i && cond_pass_i;
   endsequence
   sequence s_skip;
      issue_valid_i && !cond_pass_i && !status_wr_i;
   endsequence
   sequence s_lane;
      issue_valid_i && !status_wr_i && op_i inside {OP_SAT_HALF_LANE_ADD,
         OP_SAT_HALF_LANE_SUB, OP_SAT_BYTE_LANE_ADD, OP_SAT_BYTE_LANE_SUB};
   endsequence

   a_wb_cause: assert property (wb_valid_o |-> $past(issue_valid_i) && $past(cond_pass_i))
      else $error("writeback without a passed issue");
   a_skip_quiet: assert property (s_skip |=> !wb_valid_o && !op_err_o && $stable(sat_flag_o))
      else $error("failed condition still acted");
   a_lane_flag: assert property (s_lane |=> $stable(sat_flag_o))
      else $error("lane operation moved the sticky flag");
   a_flag_sticky: assert property ($fell(sat_flag_o) |-> $past(rst_i) || ($past(status_wr_i) && !$past(status_wr_sat_i)))
      else $error("sticky flag cleared without a status write");
   a_clear_flag: assert property (status_wr_i && !status_wr_sat_i && !issue_valid_i |=> !sat_flag_o)
      else $error("status write of zero did not clear flag");
   a_word_ovf: assert property (s_take ##0 (op_i == OP_SAT_WORD_ADD && !opa_i[31] && !opb_i[31] && ab_sum[31]) |=> wb_valid_o && wb_data_o == 32'h7fffffff && sat_flag_o)
      else $error("word add overflow not clamped");
   a_err_asr0: assert property (s_take ##0 (op_i == OP_SIGNED_CLAMP && shift_asr_i && shift_amt_i == 5'h00) |=> op_err_o && !wb_valid_o)
      else $error("right shift by zero accepted");
   a_err_width: assert property (s_take ##0 (op_i == OP_UNSIGNED_CLAMP && sat_pos_i > UCLAMP_N_MAX) |=> op_err_o && !wb_valid_o)
      else $error("unsigned width above range accepted");
   a_rd_answer: assert property (status_rd_i |=> status_rd_valid_o && status_rd_data_o[3:0] == $past(nzcv_i) && status_rd_data_o[31:5] == 27'h0)
      else $error("status read answer wrong");
endmodule

bind sau_top sau_top_asserts u_chk (.*);

`default_nettype wire

// ### sau_top_tb.sv
`timescale 1ns/1ps
`default_nettype none

module sau_top_tb;
   import sau_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, issue_valid_i = 1'b0, cond_pass_i = 1'b0;
   logic shift_asr_i = 1'b0, status_wr_i = 1'b0, status_wr_sat_i = 1'b0;
   logic status_rd_i = 1'b0, q_exp = 1'b0;
   sau_op_t op_i = OP_SIGNED_CLAMP, op;
   logic [5:0] sat_pos_i = 6'h00, n;
   logic [4:0] shift_amt_i = 5'h00;
   logic [31:0] opa_i = 32'h0, opb_i = 32'h0, t;
   logic [3:0] dest_idx_i = 4'h0, nzcv_i = 4'h0, wb_dest_o, rf_dest;
   logic wb_valid_o, op_err_o, sat_flag_o, status_rd_valid_o;
   logic [31:0] wb_data_o, status_rd_data_o;
   int failures = 0, cmp_count = 0, seed = 23504, lo, span;

   sau_top u_dut (.*);
   sau_regfile_model u_rf (.clk_i(clk_i), .rst_i(rst_i),
      .wb_valid_i(wb_valid_o), .wb_dest_i(wb_dest_o),
      .wb_data_i(wb_data_o), .dest_o(rf_dest));

   initial forever #5 clk_i = ~clk_i;

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   function automatic logic [31:0] clamp(longint v, int w, bit u, output bit s);
      longint lo_v, hi_v, c;
      lo_v = u ? 0 : -(longint'(1) << (w - 1));
      hi_v = u ? (longint'(1) << w) - 1 : (longint'(1) << (w - 1)) - 1;
      c = (v < lo_v) ? lo_v : (v > hi_v) ? hi_v : v;
      s = (c != v);
      return c[31:0];
   endfunction

   function automatic logic [31:0] ref_op(sau_op_t o, logic [31:0] a, b,
      int w, bit arith_right_shift, int sh, output bit q);
      logic [31:0] r;
      longint v, x, y;
      bit s, u, sub;
      int xc;
      q = 0;
      r = 0;
      u = o inside {OP_UNSIGNED_CLAMP, OP_DUAL_HALF_UNSIGNED_CLAMP};
      xc = o inside {OP_SAT_ADD_SUB_EXCHANGE, OP_SAT_SUB_ADD_EXCHANGE};
      if (o inside {OP_SIGNED_CLAMP, OP_UNSIGNED_CLAMP}) begin
         v = arith_right_shift ? longint'($signed(a)) >>> sh : longint'($signed(a << sh));
         r = clamp(v, w, u, q);
      end else if (o inside {OP_SAT_WORD_ADD, OP_SAT_WORD_SUB}) begin
         x = longint'($signed(a));
         y = longint'($signed(b));
         r = clamp((o == OP_SAT_WORD_ADD) ? x + y : x - y, 32, 0, q);
      end else if (o inside {OP_SAT_BYTE_LANE_ADD, OP_SAT_BYTE_LANE_SUB}) begin
         for (int i = 0; i < 4; i++) begin
            x = longint'($signed(a[8*i+:8]));
            y = longint'($signed(b[8*i+:8]));
            v = (o == OP_SAT_BYTE_LANE_SUB) ? x - y : x + y;
            r[8*i+:8] = 8'(clamp(v, 8, 0, s));
         end
      end else begin
         for (int h = 0; h < 2; h++) begin
            x = longint'($signed(a[16*h+:16]));
            y = longint'($signed(b[16*((h + xc) % 2)+:16]));
            sub = (o == OP_SAT_HALF_LANE_SUB) ||
               (o == OP_SAT_ADD_SUB_EXCHANGE && h == 0) ||
               (o == OP_SAT_SUB_ADD_EXCHANGE && h == 1);
            if (o inside {OP_DUAL_HALF_SIGNED_CLAMP, OP_DUAL_HALF_UNSIGNED_CLAMP}) begin
               r[16*h+:16] = 16'(clamp(x, w, u, s));
               q = q | s;
            end else begin
               r[16*h+:16] = 16'(clamp(sub ? x - y : x + y, 16, 0, s));
            end
         end
      end
      return r;
   endfunction

   task automatic run(sau_op_t o, logic [31:0] a, b, logic [5:0] w,
      logic arith_right_shift, logic [4:0] sh, logic cp, logic bad);
      logic [31:0] r;
      logic [3:0] d;
      bit q;
      r = ref_op(o, a, b, int'(w), arith_right_shift, int'(sh), q);
      @(posedge clk_i);
      d = rf_dest;
      issue_valid_i <= 1'b1;
      op_i <= o;
      opa_i <= a;
      opb_i <= b;
      sat_pos_i <= w;
      shift_asr_i <= arith_right_shift;
      shift_amt_i <= sh;
      cond_pass_i <= cp;
      dest_idx_i <= d;
      @(posedge clk_i);
      issue_valid_i <= 1'b0;
      #1;
      check("wb_valid", wb_valid_o, cp && !bad);
      check("op_err", op_err_o, cp && bad);
      if (cp && !bad) begin
         q_exp = q_exp | q;
         check("wb_data", wb_data_o, r);
         check("wb_dest", wb_dest_o, d);
      end
      check("sat_flag", sat_flag_o, q_exp);
   endtask

   task automatic stat(logic wr, logic val);
      logic [3:0] f;
      f = 4'($random(seed));
      @(posedge clk_i);
      status_wr_i <= wr;
      status_wr_sat_i <= val;
      status_rd_i <= !wr;
      nzcv_i <= f;
      @(posedge clk_i);
      status_wr_i <= 1'b0;
      status_rd_i <= 1'b0;
      #1;
      if (wr) q_exp = val;
      check("sat_flag", sat_flag_o, q_exp);
      if (!wr) begin
         check("rd_valid", status_rd_valid_o, 1'b1);
         check("rd_data", status_rd_data_o, {27'h0, q_exp, f});
      end
   endtask

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 288; i++) begin
         op = sau_op_t'(12'h001 << (i % 12));
         lo = op inside {OP_SIGNED_CLAMP, OP_DUAL_HALF_SIGNED_CLAMP};
         span = op inside {OP_SIGNED_CLAMP, OP_UNSIGNED_CLAMP} ? 32 : 16;
         t = $random(seed);
         n = 6'(lo + ((i < 24) ? (i / 12) * (span - 1) : t % span));
         run(op, $random(seed), $random(seed), n, t[31],
            t[31] ? 5'(1 + t[20:16] % 31) : t[20:16], (i % 7) != 3, 1'b0);
         if (i % 50 == 0) stat(1'b0, 1'b0);
      end
      $display("test sweep done");
      run(OP_SIGNED_CLAMP, 32'h80000000, 32'h0, 6'h10, 1, 5'h00, 1, 1);
      run(OP_SIGNED_CLAMP, 32'h7fffffff, 32'h0, 6'h00, 0, 5'h00, 1, 1);
      run(OP_UNSIGNED_CLAMP, 32'h1, 32'h0, 6'h20, 0, 5'h00, 1, 1);
      run(OP_DUAL_HALF_SIGNED_CLAMP, 32'h1, 32'h0, 6'h11, 0, 5'h00, 1, 1);
      run(OP_DUAL_HALF_UNSIGNED_CLAMP, 32'h1, 32'h0, 6'h10, 0, 5'h00, 1, 1);
      $display("test illegal done");
      stat(1'b0, 1'b0);
      stat(1'b1, 1'b0);
      stat(1'b0, 1'b0);
      run(OP_SAT_WORD_ADD, 32'h7fffffff, 32'h1, 6'h00, 0, 5'h00, 1, 0);
      run(OP_SAT_WORD_SUB, 32'h0, 32'h1, 6'h00, 0, 5'h00, 0, 0);
      stat(1'b0, 1'b0);
      stat(1'b1, 1'b1);
      stat(1'b1, 1'b0);
      $display("test status done");
      test_done();
   end

   initial begin
      #100000;
      failures++;
      test_done();
   end
endmodule

`default_nettype wire
